// ---- fwp_pkg.sv ----
// package of constants and carrier types for the fifo write port control
`default_nettype none
package fwp_pkg;
  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int unsigned DATA_W = 36;
  localparam int unsigned DEPTH = 1024;
  localparam int unsigned ADDR_W = $clog2(DEPTH);
  localparam int unsigned OFFS_W = ADDR_W;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PTR_RST = 10'h000;
  localparam logic [OFFS_W-1:0] EMPTY_OFFS_RST = 10'h07F;
  localparam logic [OFFS_W-1:0] FULL_OFFS_RST = 10'h07F;
  localparam logic [ADDR_W:0] COUNT_RST = 11'h000;
  // -----------------------------------------------------------------
  // timing counts
  // -----------------------------------------------------------------
  // clock edges after reset release before the strap has crossed both sync flops
  localparam logic [1:0] CFG_SETTLE = 2'h2;

  // write-side states: offset loading steps through empty then full offset
  typedef enum logic [1:0] {
    FWP_LD_EMPTY = 2'b00,
    FWP_LD_FULL = 2'b01,
    FWP_LD_DONE = 2'b11
  } fwp_ld_state_t;

  // one write request as presented on the input side pins
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic enable_n;
    logic input_side_select_n;
    logic load_n;
  } fwp_req_t;

  // static configuration straps caught at master reset release
  typedef struct packed {
    logic async_mode;
  } fwp_cfg_t;
endpackage
`default_nettype wire

// ---- fwp_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`default_nettype none
module fwp_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side and clock side
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second
  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// ---- fwp_write_port.sv ----
// write port gating logic of a 36-bit fifo: memory, pointer and offset loading
`default_nettype none
module fwp_write_port #(
  parameter int unsigned DATA_W = fwp_pkg::DATA_W,
  parameter int unsigned DEPTH = fwp_pkg::DEPTH
) (
  // clock and master reset
  input wire logic clk,
  input wire logic rst,
  // write side pins, all from outside the clock domain
  input wire logic write_clock_pin,
  input wire logic [DATA_W-1:0] data_pin,
  input wire logic enable_n_pin,
  input wire logic input_side_select_n_pin,
  input wire logic load_n_pin,
  input wire logic async_mode_pin,
  // read back of stored words
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  // write side status
  output logic [$clog2(DEPTH)-1:0] write_ptr,
  output logic [$clog2(DEPTH):0] write_count,
  output logic [$clog2(DEPTH)-1:0] empty_offset,
  output logic [$clog2(DEPTH)-1:0] full_offset,
  output logic write_pulse
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned SW = DATA_W + 5;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_sync;
  fwp_pkg::fwp_req_t req;
  logic wclk_s;
  logic async_s;

  assign pins_raw = {write_clock_pin, async_mode_pin, data_pin, enable_n_pin,
                     input_side_select_n_pin, load_n_pin};

  fwp_sync2 #(.W(SW)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_i(pins_raw),
    .sync_o(pins_sync)
  );

  assign wclk_s = pins_sync[SW-1];
  assign async_s = pins_sync[SW-2];
  assign req = fwp_pkg::fwp_req_t'(pins_sync[SW-3:0]);

  // ---------------------------------------------------------------
  // edge detect and configuration capture
  // ---------------------------------------------------------------
  logic wclk_last_q;
  logic wclk_last_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic cfg_taken;
  fwp_pkg::fwp_cfg_t cfg_q;
  fwp_pkg::fwp_cfg_t cfg_d;
  logic rise;

  assign rise = wclk_s & ~wclk_last_q;
  assign cfg_taken = (settle_q > fwp_pkg::CFG_SETTLE);

  // reset clears the sync flops, so the strap is caught only once it has
  // crossed both of them; it is then frozen and later pin changes are ignored
  always_comb begin
    wclk_last_d = wclk_s;
    settle_d = settle_q;
    cfg_d = cfg_q;
    if (!cfg_taken) begin
      settle_d = settle_q + 2'h1;
    end
    if (settle_q == fwp_pkg::CFG_SETTLE) begin
      cfg_d.async_mode = async_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wclk_last_q <= 1'b0;
      settle_q <= 2'h0;
      cfg_q <= '0;
    end else begin
      wclk_last_q <= wclk_last_d;
      settle_q <= settle_d;
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------
  // write qualification
  // ---------------------------------------------------------------
  logic qualified;
  logic mem_wr;
  logic offs_wr;

  // qualifying function shared by both modes
  function automatic logic fwp_qual(input logic async_m, input logic en_n,
                                    input logic sel_n);
    // async mode relies on the writer holding enable low, so only the
    // chip select gates the strobe there
    if (async_m) begin
      fwp_qual = ~sel_n;
    end else begin
      fwp_qual = ~en_n & ~sel_n;
    end
  endfunction

  always_comb begin
    qualified = rise & cfg_taken & fwp_qual(cfg_q.async_mode, req.enable_n,
                                               req.input_side_select_n);
    // offset loading only through the synchronous, enabled port
    offs_wr = qualified & ~cfg_q.async_mode & ~req.load_n;
    mem_wr = qualified & ~offs_wr;
  end

  // ---------------------------------------------------------------
  // memory, pointer and count
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] ptr_d;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic [DATA_W-1:0] rd_q;
  logic pulse_q;

  // pointer moves only on a stored word; count saturates at depth
  always_comb begin
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    if (mem_wr) begin
      ptr_d = AW'(ptr_q + 1'b1);
      if (cnt_q != (AW+1)'(DEPTH)) begin
        cnt_d = (AW+1)'(cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= fwp_pkg::PTR_RST;
      cnt_q <= fwp_pkg::COUNT_RST;
      pulse_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      pulse_q <= mem_wr;
    end
  end

  // memory array has no reset; an unqualified edge writes nothing
  always_ff @(posedge clk) begin
    if (mem_wr) begin
      mem[ptr_q] <= req.data;
    end
    rd_q <= mem[rd_addr];
  end

  // ---------------------------------------------------------------
  // programmable offset registers
  // ---------------------------------------------------------------
  fwp_pkg::fwp_ld_state_t ld_q;
  fwp_pkg::fwp_ld_state_t ld_d;
  logic [AW-1:0] eoffs_q;
  logic [AW-1:0] eoffs_d;
  logic [AW-1:0] foffs_q;
  logic [AW-1:0] foffs_d;

  // each enabled load edge takes the next offset; after the full offset
  // the sequence wraps so software can rewrite both
  always_comb begin
    ld_d = ld_q;
    eoffs_d = eoffs_q;
    foffs_d = foffs_q;
    if (offs_wr) begin
      case (ld_q)
        fwp_pkg::FWP_LD_EMPTY: begin
          eoffs_d = req.data[AW-1:0];
          ld_d = fwp_pkg::FWP_LD_FULL;
        end
        fwp_pkg::FWP_LD_FULL: begin
          foffs_d = req.data[AW-1:0];
          ld_d = fwp_pkg::FWP_LD_DONE;
        end
        fwp_pkg::FWP_LD_DONE: begin
          eoffs_d = req.data[AW-1:0];
          ld_d = fwp_pkg::FWP_LD_FULL;
        end
        default: begin
          ld_d = fwp_pkg::FWP_LD_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_q <= fwp_pkg::FWP_LD_EMPTY;
      eoffs_q <= fwp_pkg::EMPTY_OFFS_RST;
      foffs_q <= fwp_pkg::FULL_OFFS_RST;
    end else begin
      ld_q <= ld_d;
      eoffs_q <= eoffs_d;
      foffs_q <= foffs_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data = rd_q;
  assign write_ptr = ptr_q;
  assign write_count = cnt_q;
  assign empty_offset = eoffs_q;
  assign full_offset = foffs_q;
  assign write_pulse = pulse_q;
endmodule
`default_nettype wire

// ---- fwp_write_port_properties.sv ----
// checker of write port gating and pointer timing
`default_nettype none
module fwp_write_port_properties #(
  parameter int unsigned DATA_W = 36,
  parameter int unsigned DEPTH = 1024
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched pins and status
  input wire logic enable_n_pin,
  input wire logic input_side_select_n_pin,
  input wire logic load_n_pin,
  input wire logic async_mode_pin,
  input wire logic [$clog2(DEPTH)-1:0] write_ptr,
  input wire logic [$clog2(DEPTH)-1:0] empty_offset,
  input wire logic [$clog2(DEPTH)-1:0] full_offset,
  input wire logic write_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // six samples span both sync flops and the edge detect, so no write can slip in
  chk_ptr_step_one:
  assert property ($changed(write_ptr) |-> write_ptr == $past(write_ptr) + 1'b1)
    else $error("write pointer stepped wrong");
  chk_pulse_follows_write:
  assert property ($changed(write_ptr) |-> write_pulse ##1 !write_pulse)
    else $error("write pulse missing or long");
  chk_offset_gated:
  assert property ((enable_n_pin || input_side_select_n_pin)[*6]
    |-> $stable(empty_offset) && $stable(full_offset)) else $error("offset loaded ungated");
  chk_load_no_write:
  assert property ((!load_n_pin && !async_mode_pin)[*6] |-> $stable(write_ptr))
    else $error("offset load wrote memory");
  chk_select_gates_write:
  assert property (input_side_select_n_pin[*6] |-> $stable(write_ptr) && !write_pulse)
    else $error("write while deselected");
  chk_enable_gates_write:
  assert property ((enable_n_pin && !async_mode_pin)[*6] |-> $stable(write_ptr))
    else $error("write while disabled");
endmodule

bind fwp_write_port fwp_write_port_properties #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk (
  .clk, .rst, .enable_n_pin, .input_side_select_n_pin, .load_n_pin, .async_mode_pin,
  .write_ptr, .empty_offset, .full_offset, .write_pulse);
`default_nettype wire

// ---- fwp_writer_model.sv ----
// behavioural external writer driving the write side pins
`default_nettype none
module fwp_writer_model (
  // clock
  input wire logic clk,
  // write side pins
  output var fwp_pkg::fwp_req_t req,
  output var logic write_clock,
  output var logic async_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle pins at time zero, strobe standing low
  initial begin
    req = '{data: 36'h0, enable_n: 1'b1, input_side_select_n: 1'b1, load_n: 1'b1};
    write_clock = 1'b0;
    async_mode = 1'b0;
  end
  // called only while reset is held, so the strap never moves in operation
  task automatic set_mode(input logic m);
    async_mode = m;
    req.enable_n = ~m;
  endtask
  // one strobe, qualifiers held 3 cycles either side so the synced edge sees them
  task automatic put(input logic [35:0] d, input logic en_n, input logic sel_n,
                     input logic ld_n);
    @(negedge clk);
    req = '{data: d, enable_n: async_mode ? 1'b0 : en_n, input_side_select_n: sel_n,
            load_n: ld_n};
    repeat (3) @(negedge clk);
    write_clock = 1'b1;
    repeat (3) @(negedge clk);
    write_clock = 1'b0;
    repeat (3) @(negedge clk);
    // released data flips so a stale word never looks valid
    req = '{data: ~d, enable_n: ~async_mode, input_side_select_n: 1'b1, load_n: 1'b1};
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the write port gating
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] rd_addr = 10'h000;
  fwp_pkg::fwp_req_t req;
  logic wclk;
  logic amode;
  logic [35:0] rd_data;
  logic [9:0] write_ptr;
  logic [9:0] empty_offset;
  logic [9:0] full_offset;
  logic [10:0] write_count;
  logic write_pulse;
  logic [9:0] exp_ptr;
  int fail_count = 0;
  int n_tests = 0;
  // rows: data, enable_n, select_n, load_n
  logic [38:0] rows [5] = '{{36'hA5A5A5A5A, 3'b001}, {36'h123456789, 3'b101},
    {36'hFEDCBA987, 3'b011}, {36'h0F0F0F0F0, 3'b111}, {36'h5A5A5A5A5, 3'b001}};
  fwp_writer_model w (.clk, .req, .write_clock(wclk), .async_mode(amode));
  fwp_write_port dut (.clk, .rst, .write_clock_pin(wclk), .data_pin(req.data),
    .enable_n_pin(req.enable_n), .input_side_select_n_pin(req.input_side_select_n),
    .load_n_pin(req.load_n), .async_mode_pin(amode), .rd_addr, .rd_data, .write_ptr,
    .write_count, .empty_offset, .full_offset, .write_pulse);
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic chk(input string name, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask
  // read port has one cycle of latency
  task automatic rd(input logic [9:0] a, input logic [35:0] d);
    @(negedge clk) rd_addr = a;
    @(negedge clk);
    chk("rd_data", d, rd_data);
  endtask
  // strap moves only inside reset, then the sync pipe gets 3 cycles to settle
  task automatic do_reset(input logic m);
    @(negedge clk) rst = 1'b1;
    w.set_mode(m);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    exp_ptr = 10'h000;
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // about 140 cycles are needed; far more means a hang
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      w.put(rows[i][38:3], rows[i][2], rows[i][1], rows[i][0]);
      if (!rows[i][2] && !rows[i][1]) begin
        rd(exp_ptr, rows[i][38:3]);
        exp_ptr++;
      end
      chk("write_ptr", {26'h0, exp_ptr}, {26'h0, write_ptr});
    end
    // offset loads: empty, then a gated one refused, then full
    w.put(36'h000000012, 1'b0, 1'b0, 1'b0);
    w.put(36'h000000345, 1'b1, 1'b0, 1'b0);
    w.put(36'h0000001AB, 1'b0, 1'b0, 1'b0);
    chk("empty_offset", 36'h012, {26'h0, empty_offset});
    chk("full_offset", 36'h1AB, {26'h0, full_offset});
    chk("write_count", 36'h2, {25'h0, write_count});
    // mid-run reset into strobe mode
    do_reset(1'b1);
    chk("rst_count", 36'h0, {25'h0, write_count});
    chk("rst_offset", 36'h07F, {26'h0, empty_offset});
    chk("rst_full", 36'h07F, {26'h0, full_offset});
    w.put(36'hC3C3C3C3C, 1'b1, 1'b0, 1'b1);
    rd(10'h000, 36'hC3C3C3C3C);
    w.put(36'h111111111, 1'b0, 1'b1, 1'b1);
    w.put(36'h222222222, 1'b0, 1'b0, 1'b0);
    rd(10'h001, 36'h222222222);
    chk("async_ptr", 36'h2, {26'h0, write_ptr});
    chk("async_offset", 36'h07F, {26'h0, empty_offset});
    summarize();
  end
endmodule
`default_nettype wire
